/* File: design/nvw_cycle_timer.sv */
// Down counter that times one store operation.
// Assumes load is at least one and start is a single-cycle pulse.
`timescale 1ns/1ns
module nvw_cycle_timer #(
    parameter int CNT_W = nvw_pkg::CNT_W_DEF
) (
    input wire logic ref_clk,
    input wire logic rst,
    nvw_tmr_if.tmr   tmr
);
    import nvw_pkg::*;

    localparam logic [CNT_W-1:0] ONE = CNT_W'(1);

    logic [CNT_W-1:0] count_reg;

    // ------------------------------------------------------------
    // Counter
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            count_reg <= '0;
        end else if (tmr.start) begin
            count_reg <= tmr.load;
        end else if (count_reg != '0) begin
            count_reg <= count_reg - ONE;
        end
    end

    // Last cycle of the operation
    assign tmr.done = (count_reg == ONE);

endmodule : nvw_cycle_timer

/* File: design/nvw_pkg.sv */
// Shared constants, register map and state codes for the nonvolatile word store.
// Assumes a 125 MHz system clock and a byte-wide CPU register port.
package nvw_pkg;

    // ------------------------------------------------------------
    // Array geometry
    // ------------------------------------------------------------
    localparam int WORDS      = 32;
    localparam int DATA_W     = 14;
    localparam int ADDR_W     = 5;
    localparam int PAGE_WORDS = 16;
    localparam int PAGE_BIT   = 4;

    // ------------------------------------------------------------
    // Register port and map
    // ------------------------------------------------------------
    localparam int REG_W = 8;
    localparam int OFS_W = 2;
    localparam int DHI_W = DATA_W - REG_W;
    localparam logic [OFS_W-1:0] OFS_ADDR = 2'h0;
    localparam logic [OFS_W-1:0] OFS_DLO  = 2'h1;
    localparam logic [OFS_W-1:0] OFS_DHI  = 2'h2;
    localparam logic [OFS_W-1:0] OFS_CTRL = 2'h3;
    localparam logic [REG_W-1:0] RST_BYTE = 8'h00;

    // Control register fields
    localparam int B_RD_START = 0;
    localparam int B_RD_EN    = 1;
    localparam int B_WR_START = 2;
    localparam int B_WR_EN    = 3;
    localparam int B_ER_START = 4;
    localparam int B_ER_EN    = 5;
    localparam int B_DUR_LO   = 6;
    localparam int DUR_W      = 2;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_MHZ   = 125;
    localparam int T_2MS_US  = 2000;
    localparam int BASE_CYC  = T_2MS_US * CLK_MHZ;
    localparam int READ_CYC  = 2;
    localparam int CNT_W_DEF = 24;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_ERASE = 2'b01,
        ST_WRITE = 2'b10,
        ST_READ  = 2'b11
    } nvw_state_t;

endpackage : nvw_pkg

/* File: design/nvw_store_ctrl.sv */
// Sequencer, registers and word array of the nonvolatile word store.
// Assumes the CPU halts while cpu_stall is high and issues single-cycle strobes.
`timescale 1ns/1ns
// ------------------------------------------------------------
// What this block does
// - Store holds 32 words of 14 bits
// - Erase one 16-word page, write/read one word
// - Erase page chosen by address bit 4
// - Five-bit address, upper bits read zero
// - Data split low byte, high six bits
// - Duration codes 01/10/11 give 4/8/16 ms
// - Erase enable gates erase, clears when done
// - Erase start needs enable, busy, self-clears
// - Write enable gates write, clears when done
// - Write start needs enable, self-clears
// - Read enable gates read, stays set
// - Read start needs enable, self-clears
// - CPU stalled until launched operation ends
// - Erase start must directly follow enable
// - Erased page reads back all zeros
// - Duration code 00 gives 2 ms
// - Write stores data registers at address
// - Read loads data registers, kept after
// ------------------------------------------------------------
module nvw_store_ctrl #(
    parameter int CYC_2MS = nvw_pkg::BASE_CYC,
    parameter int CNT_W   = nvw_pkg::CNT_W_DEF
) (
    input  wire logic                      ref_clk,
    input  wire logic                      rst,
    input  wire logic [nvw_pkg::OFS_W-1:0] reg_addr,
    input  wire logic [nvw_pkg::REG_W-1:0] reg_wdata,
    input  wire logic                      reg_wr,
    input  wire logic                      reg_rd,
    output logic      [nvw_pkg::REG_W-1:0] reg_rdata,
    output logic                           cpu_stall
);
    import nvw_pkg::*;

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    nvw_tmr_if #(.CNT_W(CNT_W)) tmr ();

    nvw_state_t        state_reg;
    nvw_state_t        state_next;
    logic [ADDR_W-1:0] addr_reg;
    logic [REG_W-1:0]  dlo_reg;
    logic [DHI_W-1:0]  dhi_reg;
    logic [REG_W-1:0]  ctrl_reg;
    logic [REG_W-1:0]  ctrl_next;
    logic [REG_W-1:0]  rdata_reg;
    logic              er_armed_reg;
    logic              stall_reg;
    logic [DATA_W-1:0] mem [WORDS];

    // ------------------------------------------------------------
    // Decode helpers
    // ------------------------------------------------------------
    function automatic logic wr_hit(input logic [OFS_W-1:0] a,
                                    input logic [OFS_W-1:0] ofs);
        return a == ofs;
    endfunction : wr_hit

    function automatic logic in_page(input logic [ADDR_W-1:0] a,
                                     input logic [ADDR_W-1:0] b);
        return a[PAGE_BIT] == b[PAGE_BIT];
    endfunction : in_page

    // Base count doubles per code step
    function automatic logic [CNT_W-1:0] dur_cycles(input logic [DUR_W-1:0] sel);
        return CNT_W'(CYC_2MS) << sel;
    endfunction : dur_cycles

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    // Writes are refused while busy; the stalled CPU should not issue any
    wire idle     = (state_reg == ST_IDLE);
    wire wr_ok    = reg_wr && idle;
    wire addr_wr  = wr_ok && wr_hit(reg_addr, OFS_ADDR);
    wire dlo_wr   = wr_ok && wr_hit(reg_addr, OFS_DLO);
    wire dhi_wr   = wr_ok && wr_hit(reg_addr, OFS_DHI);
    wire ctrl_wr  = wr_ok && wr_hit(reg_addr, OFS_CTRL);

    wire [DUR_W-1:0] dur_new = reg_wdata[B_DUR_LO +: DUR_W];
    wire [DUR_W-1:0] dur_cur = ctrl_reg[B_DUR_LO +: DUR_W];

    // ------------------------------------------------------------
    // Launch decode
    // ------------------------------------------------------------
    // Enable must already be high from an earlier write
    wire er_launch = ctrl_wr && reg_wdata[B_ER_START] && ctrl_reg[B_ER_EN]
                     && er_armed_reg;
    wire wr_launch = ctrl_wr && reg_wdata[B_WR_START] && ctrl_reg[B_WR_EN];
    wire rd_launch = ctrl_wr && reg_wdata[B_RD_START] && ctrl_reg[B_RD_EN];
    wire launch    = er_launch || wr_launch || rd_launch;

    wire finish = !idle && tmr.done;
    wire er_fin = finish && (state_reg == ST_ERASE);
    wire wr_fin = finish && (state_reg == ST_WRITE);
    wire rd_fin = finish && (state_reg == ST_READ);

    wire [DATA_W-1:0] word_w = {dhi_reg, dlo_reg};
    wire [DATA_W-1:0] word_r = mem[addr_reg];

    // Arm only on a 0-to-1 write of the erase enable
    wire er_arm_next = ctrl_wr && reg_wdata[B_ER_EN] && !ctrl_reg[B_ER_EN];

    // ------------------------------------------------------------
    // Timer
    // ------------------------------------------------------------
    assign tmr.start = launch;
    assign tmr.load  = rd_launch ? CNT_W'(READ_CYC) : dur_cycles(dur_new);

    nvw_cycle_timer #(
        .CNT_W (CNT_W)
    ) u_timer (
        .ref_clk (ref_clk),
        .rst     (rst),
        .tmr     (tmr.tmr)
    );

    // ------------------------------------------------------------
    // Control register next value
    // ------------------------------------------------------------
    always_comb begin
        ctrl_next = ctrl_reg;
        if (ctrl_wr) begin
            ctrl_next             = reg_wdata;
            ctrl_next[B_ER_START] = er_launch;
            ctrl_next[B_WR_START] = wr_launch;
            ctrl_next[B_RD_START] = rd_launch;
        end
        if (er_fin) begin
            ctrl_next[B_ER_EN]    = 1'b0;
            ctrl_next[B_ER_START] = 1'b0;
        end
        if (wr_fin) begin
            ctrl_next[B_WR_EN]    = 1'b0;
            ctrl_next[B_WR_START] = 1'b0;
        end
        if (rd_fin) begin
            ctrl_next[B_RD_START] = 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            ST_IDLE: begin
                if (er_launch) begin
                    state_next = ST_ERASE;
                end else if (wr_launch) begin
                    state_next = ST_WRITE;
                end else if (rd_launch) begin
                    state_next = ST_READ;
                end
            end
            ST_ERASE, ST_WRITE, ST_READ: begin
                if (tmr.done) begin
                    state_next = ST_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state_reg    <= ST_IDLE;
            ctrl_reg     <= RST_BYTE;
            er_armed_reg <= 1'b0;
            stall_reg    <= 1'b0;
        end else begin
            state_reg    <= state_next;
            ctrl_reg     <= ctrl_next;
            er_armed_reg <= er_arm_next;
            stall_reg    <= (stall_reg && !finish) || launch;
        end
    end

    // ------------------------------------------------------------
    // Address and data registers
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            addr_reg <= '0;
            dlo_reg  <= RST_BYTE;
            dhi_reg  <= '0;
        end else begin
            if (addr_wr) begin
                addr_reg <= reg_wdata[ADDR_W-1:0];
            end
            if (rd_fin) begin
                dlo_reg <= word_r[REG_W-1:0];
                dhi_reg <= word_r[DATA_W-1:REG_W];
            end else begin
                if (dlo_wr) begin
                    dlo_reg <= reg_wdata;
                end
                if (dhi_wr) begin
                    dhi_reg <= reg_wdata[DHI_W-1:0];
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Word array
    // ------------------------------------------------------------
    // No reset: contents model retained data
    for (genvar g = 0; g < WORDS; g++) begin : g_word
        always_ff @(posedge ref_clk) begin
            if (er_fin && in_page(ADDR_W'(g), addr_reg)) begin
                mem[g] <= '0;
            end else if (wr_fin && (addr_reg == ADDR_W'(g))) begin
                mem[g] <= word_w;
            end
        end
    end

    // ------------------------------------------------------------
    // Read port
    // ------------------------------------------------------------
    wire [REG_W-1:0] view =
        wr_hit(reg_addr, OFS_ADDR) ? REG_W'(addr_reg) :
        wr_hit(reg_addr, OFS_DLO)  ? dlo_reg :
        wr_hit(reg_addr, OFS_DHI)  ? REG_W'(dhi_reg) :
        ctrl_reg;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            rdata_reg <= RST_BYTE;
        end else begin
            rdata_reg <= reg_rd ? view : RST_BYTE;
        end
    end

    assign reg_rdata = rdata_reg;
    assign cpu_stall = stall_reg;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    // Cycles spent busy, read only by checks
    logic [CNT_W-1:0] op_cyc_reg;
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            op_cyc_reg <= '0;
        end else if (launch) begin
            op_cyc_reg <= CNT_W'(1);
        end else if (!idle) begin
            op_cyc_reg <= op_cyc_reg + CNT_W'(1);
        end
    end

    sequence s_erase_end;
        state_reg == ST_ERASE ##1 state_reg == ST_IDLE;
    endsequence

    sequence s_write_end;
        state_reg == ST_WRITE ##1 state_reg == ST_IDLE;
    endsequence

    sequence s_read_end;
        state_reg == ST_READ ##1 state_reg == ST_IDLE;
    endsequence

    a_stall_follows_op: assert property (
        (idle && launch) |=> cpu_stall throughout (!idle [*1])
    ) else $error("stall not raised with operation");

    a_stall_ends_idle: assert property (
        (cpu_stall && finish) |=> !cpu_stall && idle
    ) else $error("stall not released at end");

    a_erase_dur_exact: assert property (
        er_fin |-> op_cyc_reg == dur_cycles(dur_cur)
    ) else $error("erase length wrong");

    a_write_dur_exact: assert property (
        wr_fin |-> op_cyc_reg == dur_cycles(dur_cur)
    ) else $error("write length wrong");

    a_erase_busy_flag: assert property (
        state_reg == ST_ERASE |-> ctrl_reg[B_ER_START] && ctrl_reg[B_ER_EN]
    ) else $error("erase start not shown busy");

    a_erase_needs_arm: assert property (
        $rose(state_reg == ST_ERASE) |-> $past(er_armed_reg) && $past(ctrl_reg[B_ER_EN], 2) == 1'b0
    ) else $error("erase launched without back-to-back enable");

    a_erase_clears: assert property (
        s_erase_end |-> !ctrl_reg[B_ER_EN] && !ctrl_reg[B_ER_START]
    ) else $error("erase bits not cleared");

    a_write_clears: assert property (
        s_write_end |-> !ctrl_reg[B_WR_EN] && !ctrl_reg[B_WR_START]
    ) else $error("write bits not cleared");

    a_read_keeps_en: assert property (
        (rd_fin && ctrl_reg[B_RD_EN]) |=> ctrl_reg[B_RD_EN] && !ctrl_reg[B_RD_START]
    ) else $error("read enable lost or start stuck");

    a_page_zeroed: assert property (
        s_erase_end |-> mem[{addr_reg[PAGE_BIT], 4'h0}] == '0 && mem[{addr_reg[PAGE_BIT], 4'hf}] == '0
    ) else $error("erased page not zero");

    a_write_stores: assert property (
        s_write_end |-> mem[addr_reg] == word_w
    ) else $error("written word not stored");

    a_read_loads: assert property (
        s_read_end |-> {dhi_reg, dlo_reg} == $past(word_r)
    ) else $error("read data not loaded");

    a_addr_upper_zero: assert property (
        (reg_rd && reg_addr == OFS_ADDR) |=> reg_rdata[REG_W-1:ADDR_W] == '0
    ) else $error("address upper bits not zero");

    a_dhi_upper_zero: assert property (
        (reg_rd && reg_addr == OFS_DHI) |=> reg_rdata[REG_W-1:DHI_W] == '0
    ) else $error("high data upper bits not zero");

    a_no_launch_no_en: assert property (
        (ctrl_wr && !ctrl_reg[B_WR_EN] && !ctrl_reg[B_ER_EN] && !ctrl_reg[B_RD_EN]) |=> idle && !cpu_stall
    ) else $error("operation started without enable");

endmodule : nvw_store_ctrl

/* File: design/nvw_tmr_if.sv */
// Link between the sequencer and its cycle timer.
// Assumes both ends run on the same clock.
`timescale 1ns/1ns
interface nvw_tmr_if #(parameter int CNT_W = nvw_pkg::CNT_W_DEF);
    logic             start;
    logic [CNT_W-1:0] load;
    logic             done;
    modport ctrl (output start, output load, input done);
    modport tmr  (input start, input load, output done);
endinterface : nvw_tmr_if

/* File: testbench/nvw_cpu_model.sv */
// CPU side of the register port: byte writes and reads, halting while stalled.
// Assumes the caller enters each task just after a rising clock edge.
`timescale 1ns/1ns
module nvw_cpu_model
    import nvw_pkg::*;
(
    input  wire logic                       ref_clk,
    input  wire logic                       cpu_stall,
    input  wire logic [nvw_pkg::REG_W-1:0]  reg_rdata,
    output logic      [nvw_pkg::OFS_W-1:0]  reg_addr,
    output logic      [nvw_pkg::REG_W-1:0]  reg_wdata,
    output logic                            reg_wr,
    output logic                            reg_rd
);
    initial begin
        reg_addr  = OFS_ADDR;
        reg_wdata = RST_BYTE;
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
    end

    // ------------------------------------------------------------
    // Bus cycles
    // ------------------------------------------------------------
    // Halted core issues nothing until the operation ends
    task automatic hold_off();
        while (cpu_stall === 1'b1) begin
            @(posedge ref_clk);
        end
    endtask : hold_off

    // Strobe left high so back-to-back writes keep one assignment per step
    task automatic wr(input logic [OFS_W-1:0] ofs, input logic [REG_W-1:0] d);
        hold_off();
        reg_addr  <= ofs;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge ref_clk);
    endtask : wr

    task automatic idle();
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
    endtask : idle

    task automatic rd(input logic [OFS_W-1:0] ofs, output logic [REG_W-1:0] d);
        hold_off();
        reg_addr <= ofs;
        reg_wr   <= 1'b0;
        reg_rd   <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        @(negedge ref_clk);
        d = reg_rdata;
        @(posedge ref_clk);
    endtask : rd
endmodule : nvw_cpu_model

/* File: testbench/nvw_store_ctrl_tb.sv */
// Self-checking bench for the nonvolatile word store controller.
// Assumes a shortened 2 ms count so every duration is a few cycles.
`timescale 1ns/1ns
module nvw_store_ctrl_tb;
    import nvw_pkg::*;
    localparam int N = 4;

    logic               ref_clk;
    logic               rst;
    logic [OFS_W-1:0]   reg_addr;
    logic [REG_W-1:0]   reg_wdata;
    logic               reg_wr;
    logic               reg_rd;
    logic [REG_W-1:0]   reg_rdata;
    logic               cpu_stall;
    int                 err_count;
    int                 samples_checked;
    int                 cyc;
    logic [REG_W-1:0]   d;
    int                 n;

    initial ref_clk = 1'b0;
    always #4 ref_clk = ~ref_clk;

    nvw_store_ctrl #(.CYC_2MS(N), .CNT_W(CNT_W_DEF)) i_nvw_store_ctrl (
        .ref_clk   (ref_clk),
        .rst       (rst),
        .reg_addr  (reg_addr),
        .reg_wdata (reg_wdata),
        .reg_wr    (reg_wr),
        .reg_rd    (reg_rd),
        .reg_rdata (reg_rdata),
        .cpu_stall (cpu_stall)
    );

    nvw_cpu_model i_nvw_cpu_model (
        .ref_clk   (ref_clk),
        .cpu_stall (cpu_stall),
        .reg_rdata (reg_rdata),
        .reg_addr  (reg_addr),
        .reg_wdata (reg_wdata),
        .reg_wr    (reg_wr),
        .reg_rd    (reg_rd)
    );

    // ------------------------------------------------------------
    // Checking and closing
    // ------------------------------------------------------------
    task automatic chk(input logic [REG_W-1:0] got, input logic [REG_W-1:0] exp, input string what);
        samples_checked++;
        if (got !== exp) begin
            err_count++;
            $display("FAIL %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk

    task automatic results();
        $display("mismatches %0d checks %0d", err_count, samples_checked);
        if (err_count == 0 && samples_checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : results

    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 20000) begin
            err_count++;
            $display("FAIL %0t timeout", $time);
            results();
        end
    end

    // ------------------------------------------------------------
    // Operations
    // ------------------------------------------------------------
    // Counts stall cycles after the launching write; bounded against a hang
    task automatic op(input logic [REG_W-1:0] en, input logic [REG_W-1:0] go, output int cnt);
        i_nvw_cpu_model.wr(OFS_CTRL, en);
        i_nvw_cpu_model.wr(OFS_CTRL, go);
        i_nvw_cpu_model.idle();
        cnt = 0;
        @(negedge ref_clk);
        while (cpu_stall === 1'b1 && cnt < 300) begin
            cnt++;
            @(negedge ref_clk);
        end
        @(posedge ref_clk);
    endtask : op

    // Data registers cleared first so the read's own load is seen
    task automatic rdword(input logic [REG_W-1:0] a, input logic [DATA_W-1:0] exp);
        i_nvw_cpu_model.wr(OFS_ADDR, a);
        i_nvw_cpu_model.wr(OFS_DLO, 8'h00);
        i_nvw_cpu_model.wr(OFS_DHI, 8'h00);
        op(8'h02, 8'h03, n);
        chk(8'(n), 8'(READ_CYC), "read stall");
        i_nvw_cpu_model.rd(OFS_CTRL, d);
        chk(d, 8'h02, "read enable kept");
        i_nvw_cpu_model.rd(OFS_DLO, d);
        chk(d, exp[7:0], "word low");
        i_nvw_cpu_model.rd(OFS_DHI, d);
        chk(d, {2'h0, exp[13:8]}, "word high");
    endtask : rdword

    task automatic wrword(input logic [REG_W-1:0] a, input logic [DATA_W-1:0] w);
        i_nvw_cpu_model.wr(OFS_ADDR, a);
        i_nvw_cpu_model.wr(OFS_DLO, w[7:0]);
        i_nvw_cpu_model.wr(OFS_DHI, {2'h0, w[13:8]});
        op(8'h08, 8'h0c, n);
        chk(8'(n), 8'(N), "write stall");
        i_nvw_cpu_model.rd(OFS_CTRL, d);
        chk(d, 8'h00, "write bits cleared");
    endtask : wrword

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        err_count = 0;
        samples_checked = 0;
        cyc = 0;
        rst = 1'b1;
        repeat (4) @(posedge ref_clk);
        rst <= 1'b0;
        @(posedge ref_clk);
        for (int r = 0; r < 4; r++) begin
            i_nvw_cpu_model.rd(r[1:0], d);
            chk(d, RST_BYTE, "reset value");
        end
        i_nvw_cpu_model.wr(OFS_ADDR, 8'hff);
        i_nvw_cpu_model.wr(OFS_DLO, 8'ha5);
        i_nvw_cpu_model.wr(OFS_DHI, 8'hff);
        i_nvw_cpu_model.idle();
        i_nvw_cpu_model.rd(OFS_ADDR, d);
        chk(d, 8'h1f, "address width");
        i_nvw_cpu_model.rd(OFS_DLO, d);
        chk(d, 8'ha5, "data low");
        i_nvw_cpu_model.rd(OFS_DHI, d);
        chk(d, 8'h3f, "data high width");
        // Start bits without their enable must do nothing
        for (int i = 0; i < REG_W; i++) begin
            if (i == 0 || i == 2 || i == 4) begin
                i_nvw_cpu_model.wr(OFS_CTRL, 8'(1 << i));
                i_nvw_cpu_model.idle();
                @(negedge ref_clk);
                chk({7'h0, cpu_stall}, 8'h00, "start refused stall");
                @(posedge ref_clk);
                i_nvw_cpu_model.rd(OFS_CTRL, d);
                chk(d, 8'h00, "start refused");
            end
        end
        // Erase start one cycle late is not a launch
        i_nvw_cpu_model.wr(OFS_CTRL, 8'h20);
        i_nvw_cpu_model.wr(OFS_ADDR, 8'h00);
        i_nvw_cpu_model.wr(OFS_CTRL, 8'h30);
        i_nvw_cpu_model.idle();
        @(negedge ref_clk);
        chk({7'h0, cpu_stall}, 8'h00, "late erase stall");
        @(posedge ref_clk);
        i_nvw_cpu_model.rd(OFS_CTRL, d);
        chk(d, 8'h20, "late erase start");
        i_nvw_cpu_model.wr(OFS_CTRL, 8'h00);
        // Every duration code, alternating pages
        for (int c = 0; c < 4; c++) begin
            i_nvw_cpu_model.wr(OFS_ADDR, {3'h0, c[0], 4'h5});
            op(8'(c << 6) | 8'h20, 8'(c << 6) | 8'h30, n);
            chk(8'(n), 8'(N << c), "erase duration");
            i_nvw_cpu_model.rd(OFS_CTRL, d);
            chk(d, 8'(c << 6), "erase bits cleared");
        end
        i_nvw_cpu_model.wr(OFS_CTRL, 8'h00);
        wrword(8'h03, 14'h2a5c);
        wrword(8'h13, 14'h15a3);
        rdword(8'h03, 14'h2a5c);
        rdword(8'h13, 14'h15a3);
        rdword(8'h04, 14'h0000);
        // Low address bits must not steer the page
        i_nvw_cpu_model.wr(OFS_ADDR, 8'h0f);
        op(8'h20, 8'h30, n);
        chk(8'(n), 8'(N), "page erase stall");
        rdword(8'h03, 14'h0000);
        rdword(8'h13, 14'h15a3);
        results();
    end
endmodule : nvw_store_ctrl_tb
